// ### hw/dac_ctl.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module dac_ctl
  import dac_ctl_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response
  input wire logic samp_valid, // Core sample strobe
  input wire dac_pair_t samp_pair, // Core offset-binary pair
  input wire logic chan_a_out_enable_n, // Pin, A enable low
  input wire logic chan_b_out_enable_n, // Pin, B enable low
  input wire logic power_down_in, // Pin, power-down high
  input wire logic mux_select, // Pin, shared bus high
  input wire dac_level_t format_stabilizer_select, // Pin level
  output logic low_power, // Core low-power request
  output logic stabilizer_en, // Duty stabilizer enable
  output logic [WORD_W-1:0] chan_a_data_bus, // Bus A data
  output logic [WORD_W-1:0] chan_a_data_oe, // Bus A enables
  output logic [WORD_W-1:0] chan_b_data_bus, // Bus B data, bit0 flag when shared
  output logic [WORD_W-1:0] chan_b_data_oe, // Bus B enables
  output logic channel_flag // Channel flag level
);
  dac_pins_t pin_s1_ff;
  dac_pins_t pin_s2_ff;
  logic [31:0] ctrl_ff;
  logic [CNT_W-1:0] recover_ff;
  logic [31:0] samples_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] rdata_ff;
  logic [WORD_W-1:0] bus_a_ff;
  logic [WORD_W-1:0] bus_b_ff;
  logic [WORD_W-1:0] hold_b_ff;
  logic pend_b_ff;
  logic flag_ff;
  logic pd_eff;
  logic twos;
  logic pipe_valid;
  dac_pair_t pipe_pair;
  logic [31:0] status;
  logic req;

  function automatic logic [WORD_W-1:0] fmt_word(input logic [WORD_W-1:0] w,
                                                 input logic to_twos);
    fmt_word = {w[WORD_W-1] ^ to_twos, w[WORD_W-2:0]};
  endfunction : fmt_word

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff <= '{oe_a_n: 1'b1, oe_b_n: 1'b1, pd: 1'b1, mux: 1'b0, fmt: LVL_FLOAT};
      pin_s2_ff <= '{oe_a_n: 1'b1, oe_b_n: 1'b1, pd: 1'b1, mux: 1'b0, fmt: LVL_FLOAT};
    end else begin
      pin_s1_ff <= '{oe_a_n: chan_a_out_enable_n, oe_b_n: chan_b_out_enable_n,
                     pd: power_down_in, mux: mux_select, fmt: format_stabilizer_select};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  assign pd_eff = pin_s2_ff.pd | ctrl_ff[CTRL_SOFT_PD_BIT];
  assign low_power = pd_eff;
  assign twos = (pin_s2_ff.fmt == LVL_GROUND) || (pin_s2_ff.fmt == LVL_MID);
  assign stabilizer_en = (pin_s2_ff.fmt == LVL_SUPPLY) || (pin_s2_ff.fmt == LVL_GROUND);

  // ---------------------------------------------------------------
  // Sample pipeline, runs whatever the enables say
  // ---------------------------------------------------------------
  dac_pipe #(.DEPTH(PIPE_LATENCY)) u_pipe (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(samp_valid),
    .in_pair(samp_pair),
    .flush(pd_eff),
    .out_valid(pipe_valid),
    .out_pair(pipe_pair)
  );

  // ---------------------------------------------------------------
  // Output words and channel flag
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_a_ff <= WORD_ZERO;
      bus_b_ff <= WORD_ZERO;
      hold_b_ff <= WORD_ZERO;
      pend_b_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else if (pd_eff) begin
      bus_a_ff <= WORD_ZERO;
      bus_b_ff <= WORD_ZERO;
      hold_b_ff <= WORD_ZERO;
      pend_b_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else if (pipe_valid) begin
      bus_a_ff <= fmt_word(pipe_pair.word_a, twos);
      bus_b_ff <= fmt_word(pipe_pair.word_b, twos);
      hold_b_ff <= fmt_word(pipe_pair.word_b, twos);
      pend_b_ff <= pin_s2_ff.mux;
      flag_ff <= 1'b1;
    end else if (pend_b_ff) begin
      bus_a_ff <= hold_b_ff;
      pend_b_ff <= 1'b0;
      flag_ff <= 1'b0;
    end
  end

  assign chan_a_data_bus = bus_a_ff;
  assign chan_b_data_bus = pin_s2_ff.mux ? {bus_b_ff[WORD_W-1:1], flag_ff} : bus_b_ff;
  assign channel_flag = flag_ff;
  assign chan_a_data_oe = {WORD_W{~pin_s2_ff.oe_a_n & ~pd_eff}};
  assign chan_b_data_oe = pin_s2_ff.mux
                        ? {{(WORD_W-1){1'b0}}, ~pin_s2_ff.oe_a_n & ~pd_eff}
                        : {WORD_W{~pin_s2_ff.oe_b_n & ~pd_eff}};

  // ---------------------------------------------------------------
  // Wake recovery and sample count
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recover_ff <= '0;
    end else if (pd_eff) begin
      recover_ff <= CNT_W'(RECOVER_CYCLES);
    end else if (recover_ff != '0) begin
      recover_ff <= recover_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samples_ff <= '0;
    end else if (samp_valid) begin
      samples_ff <= samples_ff + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait
  // ---------------------------------------------------------------
  assign req = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  always_comb begin
    status = '0;
    status[ST_OE_A_N_BIT] = pin_s2_ff.oe_a_n;
    status[ST_OE_B_N_BIT] = pin_s2_ff.oe_b_n;
    status[ST_PD_BIT] = pd_eff;
    status[ST_MUX_BIT] = pin_s2_ff.mux;
    status[ST_TWOS_BIT] = twos;
    status[ST_DCS_BIT] = stabilizer_en;
    status[ST_RECOVER_BIT] = recover_ff != '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= req & hwrite;
      rd_pend_ff <= req & ~hwrite;
      addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_pend_ff && addr_ff == ADDR_CTRL) begin
      ctrl_ff <= hwdata & 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= '0;
    end else if (req && !hwrite) begin
      if (haddr[7:0] == ADDR_CTRL) begin
        rdata_ff <= ctrl_ff;
      end else if (haddr[7:0] == ADDR_STATUS) begin
        rdata_ff <= status;
      end else if (haddr[7:0] == ADDR_SAMPLES) begin
        rdata_ff <= samples_ff;
      end else begin
        rdata_ff <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence shared_pair_s;
    pipe_valid && pin_s2_ff.mux && !pd_eff ##1 flag_ff ##1 !flag_ff;
  endsequence

  float_when_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_s2_ff.oe_a_n |-> chan_a_data_oe == '0)
    else $error("bus A driven while disabled");
  drive_when_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !pin_s2_ff.oe_a_n && !pd_eff |-> chan_a_data_oe == '1)
    else $error("bus A not driven while enabled");
  convert_while_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    samp_valid && pin_s2_ff.oe_a_n && pin_s2_ff.oe_b_n |=> samples_ff == $past(samples_ff) + 1)
    else $error("conversion stalled by enables");
  pd_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_eff |-> (chan_a_data_oe == '0 && chan_b_data_oe == '0) ##1
    (!pipe_valid && chan_a_data_bus == WORD_ZERO))
    else $error("output active in power-down");
  stab_decode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    {twos, stabilizer_en} == ((pin_s2_ff.fmt == LVL_SUPPLY) ? 2'b01 :
                              (pin_s2_ff.fmt == LVL_GROUND) ? 2'b11 :
                              (pin_s2_ff.fmt == LVL_MID) ? 2'b10 : 2'b00))
    else $error("format pin misdecoded");
  parallel_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pipe_valid && !pd_eff && !pin_s2_ff.mux ##1 !pd_eff |->
    chan_b_data_bus == {$past(pipe_pair.word_b[WORD_W-1]) ^ $past(twos),
                        $past(pipe_pair.word_b[WORD_W-2:0])})
    else $error("bus B word wrong");
  shared_order_a: assert property (@(posedge hclk) disable iff (!hresetn || pd_eff)
    pipe_valid && pin_s2_ff.mux && !pd_eff |-> shared_pair_s)
    else $error("flag not alternating");
  shared_b_word_a: assert property (@(posedge hclk) disable iff (!hresetn || pd_eff)
    shared_pair_s |-> chan_a_data_bus == $past(bus_b_ff))
    else $error("shared B word wrong");
  twos_msb_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pipe_valid && !pd_eff ##1 !pd_eff |->
    chan_a_data_bus[WORD_W-1] == ($past(pipe_pair.word_a[WORD_W-1]) ^ $past(twos)))
    else $error("coding MSB wrong");
  recover_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(pd_eff) |-> recover_ff == CNT_W'(RECOVER_CYCLES))
    else $error("recovery count not loaded");
endmodule : dac_ctl

// ### hw/dac_ctl_pkg.sv
package dac_ctl_pkg;
  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int WORD_W = 12;
  localparam int PIPE_LATENCY = 7;
  localparam int CLK_MHZ = 100;
  localparam int RECOVER_US = 500;
  localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
  localparam int CNT_W = 32;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SAMPLES = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_SOFT_PD_BIT = 0;
  localparam int ST_OE_A_N_BIT = 0;
  localparam int ST_OE_B_N_BIT = 1;
  localparam int ST_PD_BIT = 2;
  localparam int ST_MUX_BIT = 3;
  localparam int ST_TWOS_BIT = 4;
  localparam int ST_DCS_BIT = 5;
  localparam int ST_RECOVER_BIT = 6;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_SUPPLY,
    LVL_GROUND,
    LVL_MID,
    LVL_FLOAT
  } dac_level_t;

  typedef struct packed {
    logic [WORD_W-1:0] word_a;
    logic [WORD_W-1:0] word_b;
  } dac_pair_t;

  typedef struct packed {
    logic oe_a_n;
    logic oe_b_n;
    logic pd;
    logic mux;
    logic [1:0] fmt;
  } dac_pins_t;
endpackage : dac_ctl_pkg

// ### hw/dac_pipe.sv
`timescale 1ns/1ns
module dac_pipe
  import dac_ctl_pkg::*;
#(
  parameter int DEPTH = PIPE_LATENCY
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset
  input wire logic in_valid, // New sample pair
  input wire dac_pair_t in_pair, // Sample pair
  input wire logic flush, // Power-down corruption
  output logic out_valid, // Delayed strobe
  output dac_pair_t out_pair // Delayed pair
);
  dac_pair_t stage_ff [DEPTH];
  logic [DEPTH-1:0] vld_ff;

  // ---------------------------------------------------------------
  // Delay line, advances on each sample
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stage_ff[i] <= '0;
          vld_ff[i] <= 1'b0;
        end else if (flush) begin
          stage_ff[i] <= '0;
          vld_ff[i] <= 1'b0;
        end else if (in_valid) begin
          stage_ff[i] <= (i == 0) ? in_pair : stage_ff[(i == 0) ? 0 : i - 1];
          vld_ff[i] <= (i == 0) ? 1'b1 : vld_ff[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  assign out_valid = in_valid & vld_ff[DEPTH-1] & ~flush;
  assign out_pair = stage_ff[DEPTH-1];
endmodule : dac_pipe

// ### test/dac_rx_model.sv
`timescale 1ns/1ns
module dac_rx_model
  import dac_ctl_pkg::*;
(
  input wire logic hclk, // Sample clock
  input wire logic mux, // Shared bus mode
  input wire logic [WORD_W-1:0] bus_a, // Bus A data
  input wire logic [WORD_W-1:0] oe_a, // Bus A enables
  input wire logic [WORD_W-1:0] bus_b, // Bus B data
  input wire logic [WORD_W-1:0] oe_b, // Bus B enables
  input wire logic flag, // Channel flag
  output logic [WORD_W-1:0] cap_a, // Captured A word
  output logic [WORD_W-1:0] cap_b // Captured B word
);
  logic [WORD_W-1:0] wire_a;
  logic [WORD_W-1:0] wire_b;
  logic prev_flag_ff;
  // Undriven bits show the inverse level
  assign wire_a = (bus_a & oe_a) | (~bus_a & ~oe_a);
  assign wire_b = (bus_b & oe_b) | (~bus_b & ~oe_b);
  always_ff @(posedge hclk) begin
    prev_flag_ff <= flag;
    if (!mux) begin
      cap_a <= wire_a;
      cap_b <= wire_b;
    end else if (flag) begin
      cap_a <= wire_a;
    end else if (prev_flag_ff) begin
      cap_b <= wire_a;
    end
  end
endmodule : dac_rx_model

// ### test/dac_ctl_bench.sv
`timescale 1ns/1ns
module dac_ctl_bench;
  import dac_ctl_pkg::*;
  localparam int REC = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic samp_valid = 1'b0;
  dac_pair_t samp_pair = '0;
  logic oe_a_n = 1'b0;
  logic oe_b_n = 1'b0;
  logic pd = 1'b0;
  logic mux = 1'b0;
  dac_level_t fmt = LVL_SUPPLY;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic low_power;
  logic stab_en;
  logic flag;
  logic [WORD_W-1:0] bus_a, oe_a, bus_b, oe_b, cap_a, cap_b;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int nsent = 0;
  logic twos_on = 1'b0;
  logic [31:0] rd;
  dac_pair_t q[$];

  always #5 hclk = ~hclk;

  dac_ctl #(.RECOVER_CYCLES(REC)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .samp_valid(samp_valid), .samp_pair(samp_pair), .chan_a_out_enable_n(oe_a_n),
    .chan_b_out_enable_n(oe_b_n), .power_down_in(pd), .mux_select(mux),
    .format_stabilizer_select(fmt), .low_power(low_power), .stabilizer_en(stab_en),
    .chan_a_data_bus(bus_a), .chan_a_data_oe(oe_a), .chan_b_data_bus(bus_b),
    .chan_b_data_oe(oe_b), .channel_flag(flag));

  dac_rx_model rx (.hclk(hclk), .mux(mux), .bus_a(bus_a), .oe_a(oe_a), .bus_b(bus_b),
    .oe_b(oe_b), .flag(flag), .cap_a(cap_a), .cap_b(cap_b));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task conclude;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude;
    end
  end

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : ahb

  function automatic logic [11:0] ew(input logic [11:0] w);
    return twos_on ? {~w[11], w[10:0]} : w;
  endfunction : ew

  task pins(input logic an, bn, p, m, input dac_level_t f);
    @(posedge hclk);
    oe_a_n <= an;
    oe_b_n <= bn;
    pd <= p;
    mux <= m;
    fmt <= f;
    twos_on = (f == LVL_GROUND) || (f == LVL_MID);
    repeat (4) @(posedge hclk);
    #1;
  endtask : pins

  task send(input logic [11:0] a, input logic [11:0] b);
    dac_pair_t e;
    q.push_back({a, b});
    nsent++;
    @(posedge hclk);
    samp_valid <= 1'b1;
    samp_pair <= {a, b};
    @(posedge hclk);
    samp_valid <= 1'b0;
    #1;
    if (q.size() >= 8 && !pd) begin
      e = q[q.size()-8];
      if (!oe_a_n) check(bus_a, ew(e.word_a));
      if (!mux && !oe_b_n) check(bus_b, ew(e.word_b));
      if (mux && !oe_a_n) begin
        check(flag, 1'b1);
        check(bus_b[0], 1'b1);
        @(posedge hclk);
        #1;
        check(bus_a, ew(e.word_b));
        check(flag, 1'b0);
        check(bus_b[0], 1'b0);
      end
    end
    repeat (2) @(posedge hclk);
    #1;
  endtask : send

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_regs;
    ahb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, CTRL_RESET);
    check(hresp, 1'b0);
    ahb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[5:0], 6'h20);
  endtask : t_regs

  task t_format;
    for (int i = 0; i < 4; i++) begin
      pins(1'b0, 1'b0, 1'b0, 1'b0, dac_level_t'(i));
      check(stab_en, i < 2);
      ahb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[ST_TWOS_BIT], twos_on);
    end
  endtask : t_format

  task t_stream;
    pins(1'b0, 1'b0, 1'b0, 1'b0, LVL_SUPPLY);
    for (int i = 0; i < 10; i++) send(12'(i * 455 + 2048), 12'(4095 - i * 409));
    check(oe_a, 12'hfff);
    check(oe_b, 12'hfff);
    check(cap_a, ew(q[q.size()-8].word_a));
    check(cap_b, ew(q[q.size()-8].word_b));
    pins(1'b0, 1'b0, 1'b0, 1'b0, LVL_GROUND);
    send(12'h800, 12'h000);
  endtask : t_stream

  task t_enable;
    pins(1'b1, 1'b0, 1'b0, 1'b0, LVL_MID);
    send(12'h123, 12'h456);
    send(12'hfff, 12'h001);
    check(oe_a, 12'h000);
    check(oe_b, 12'hfff);
    pins(1'b1, 1'b1, 1'b0, 1'b0, LVL_MID);
    send(12'h3c3, 12'h0c0);
    check(oe_b, 12'h000);
    ahb(1'b0, ADDR_SAMPLES, 32'h0);
    check(rd, nsent);
    pins(1'b0, 1'b0, 1'b0, 1'b0, LVL_FLOAT);
    send(12'h0f0, 12'h70f);
  endtask : t_enable

  task t_shared;
    pins(1'b0, 1'b0, 1'b0, 1'b1, LVL_SUPPLY);
    repeat (3) send(12'h5a5, 12'ha5a);
    check(oe_b, 12'h001);
    check(cap_a, q[q.size()-8].word_a);
    check(cap_b, q[q.size()-8].word_b);
  endtask : t_shared

  task t_power;
    q.delete();
    pins(1'b0, 1'b0, 1'b1, 1'b0, LVL_SUPPLY);
    check(low_power, 1'b1);
    check(oe_a, 12'h000);
    check(oe_b, 12'h000);
    send(12'h111, 12'h222);
    pins(1'b0, 1'b0, 1'b0, 1'b0, LVL_SUPPLY);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[ST_RECOVER_BIT], 1'b1);
    repeat (REC + 5) @(posedge hclk);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[ST_RECOVER_BIT], 1'b0);
    q.delete();
    for (int i = 0; i < 8; i++) send(12'(i * 300 + 7), 12'(i * 200));
    ahb(1'b1, ADDR_CTRL, 32'h1);
    check(low_power, 1'b1);
    ahb(1'b1, ADDR_CTRL, 32'h0);
    check(low_power, 1'b0);
  endtask : t_power

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_regs;
    t_format;
    t_stream;
    t_enable;
    t_shared;
    t_power;
    conclude;
  end
endmodule : dac_ctl_bench
